// >>> design/fstc_trigger_ctrl.sv
`timescale 1ns/1ns
`include "fstc_map.svh"

module fstc_trigger_ctrl (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 acq_start,
  input  wire logic                 acq_stop,
  input  wire logic                 trig_mode_on,
  input  wire logic                 trig_source_sel,
  input  wire logic                 trig_source_load,
  input  wire logic                 trig_activation,
  input  wire logic                 exposure_mode,
  input  wire logic [23:0]          exposure_cycles,
  input  wire logic [15:0]          readout_cycles,
  input  wire logic                 software_trigger,
  input  wire logic                 external_frame_trigger_input,
  output fstc_pkg::fstc_status_s    status,
  output logic                      trig_source
);

  typedef struct packed {
    fstc_pkg::fstc_state_e st;
    logic                  acq_on;
    logic                  src;
    logic [23:0]           exp_cnt;
    logic [15:0]           rd_cnt;
    logic [23:0]           min_cnt;
    fstc_pkg::fstc_status_s out;
  } fstc_ctrl_s;

  fstc_ctrl_s state;
  fstc_ctrl_s next_state;

  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic ext_end;
  logic trig_evt;
  logic sw_sel;

  fstc_edge_sync u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (external_frame_trigger_input),
    .level (),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );

  // -----------------------------------------------------------------
  // trigger qualification
  // -----------------------------------------------------------------
  assign sw_sel   = (state.src == `FSTC_SRC_SOFTWARE);
  // selected edge only; line ignored when software selected
  assign ext_edge = (trig_activation == `FSTC_ACT_FALLING) ? ext_fall : ext_rise;
  // width mode ends exposure on the opposite transition
  assign ext_end  = (trig_activation == `FSTC_ACT_FALLING) ? ext_rise : ext_fall;
  assign trig_evt = trig_mode_on &
                    (sw_sel ? software_trigger : ext_edge);

  // -----------------------------------------------------------------
  // acquisition state machine
  // -----------------------------------------------------------------
  always_comb begin
    next_state                 = state;
    next_state.out.frame_start = 1'b0;
    next_state.out.frame_end   = 1'b0;
    next_state.out.overtrigger = 1'b0;
    if (trig_source_load) begin
      next_state.src = trig_source_sel;
    end
    if (acq_stop) begin
      next_state.acq_on = 1'b0;
    end else if (acq_start) begin
      next_state.acq_on = 1'b1;
    end
    if (state.min_cnt != 24'h000000) begin
      next_state.min_cnt = state.min_cnt - 24'h000001;
    end
    case (state.st)
      fstc_pkg::FSTC_IDLE: begin
        if (state.acq_on && !acq_stop) begin
          next_state.st = fstc_pkg::FSTC_WAIT;
        end
      end
      fstc_pkg::FSTC_WAIT: begin
        if (acq_stop || !state.acq_on) begin
          next_state.st = fstc_pkg::FSTC_IDLE;
        end else if (trig_evt) begin
          // one frame per accepted trigger, waiting left at once
          next_state.st              = fstc_pkg::FSTC_EXPOSE;
          next_state.out.frame_start = 1'b1;
          next_state.exp_cnt         = exposure_cycles;
          next_state.min_cnt         = exposure_cycles;
        end
      end
      fstc_pkg::FSTC_EXPOSE: begin
        // software always timed; width needs a line source
        if (exposure_mode == `FSTC_EXP_WIDTH && !sw_sel) begin
          if (ext_end) begin
            next_state.st = fstc_pkg::FSTC_READOUT;
          end
        end else if (state.exp_cnt <= 24'h000001) begin
          next_state.st = fstc_pkg::FSTC_READOUT;
        end else begin
          next_state.exp_cnt = state.exp_cnt - 24'h000001;
        end
        if (next_state.st == fstc_pkg::FSTC_READOUT) begin
          next_state.out.frame_end = 1'b1;
          next_state.rd_cnt        = readout_cycles;
        end
      end
      fstc_pkg::FSTC_READOUT: begin
        if (state.rd_cnt <= 16'h0001) begin
          // return to waiting automatically once able
          next_state.st = state.acq_on ? fstc_pkg::FSTC_WAIT
                                       : fstc_pkg::FSTC_IDLE;
        end else begin
          next_state.rd_cnt = state.rd_cnt - 16'h0001;
        end
      end
      default: begin
        next_state.st = fstc_pkg::FSTC_IDLE;
      end
    endcase
    // triggers while busy are dropped, never queued
    if (trig_evt && state.st != fstc_pkg::FSTC_WAIT) begin
      next_state.out.overtrigger = 1'b1;
    end
    next_state.out.waiting  = (next_state.st == fstc_pkg::FSTC_WAIT);
    next_state.out.exposing = (next_state.st == fstc_pkg::FSTC_EXPOSE);
    // ready follows waiting but not before the shortest exposure ran
    next_state.out.trigger_ready = (next_state.st == fstc_pkg::FSTC_WAIT) &&
                                   (next_state.min_cnt == 24'h000000);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= '0;
      state.st  <= fstc_pkg::FSTC_IDLE;
      state.src <= `FSTC_SRC_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign status      = state.out;
  assign trig_source = state.src;

endmodule // fstc_trigger_ctrl

// >>> design/fstc_map.svh
`ifndef FSTC_MAP_SVH
`define FSTC_MAP_SVH

`define FSTC_SRC_LINE1      1'b0
`define FSTC_SRC_SOFTWARE   1'b1
`define FSTC_SRC_RESET      1'b0
`define FSTC_ACT_RISING     1'b0
`define FSTC_ACT_FALLING    1'b1
`define FSTC_EXP_TIMED      1'b0
`define FSTC_EXP_WIDTH      1'b1
`define FSTC_EXP_W          24
`define FSTC_READOUT_W      16
`define FSTC_CLK_NS         8

`endif

// >>> design/fstc_pkg.sv
package fstc_pkg;

  typedef enum logic [3:0] {
    FSTC_IDLE     = 4'b0001,
    FSTC_WAIT     = 4'b0010,
    FSTC_EXPOSE   = 4'b0100,
    FSTC_READOUT  = 4'b1000
  } fstc_state_e;

  typedef struct packed {
    logic        trig_mode_on;
    logic        trig_source;
    logic        trig_activation;
    logic        exposure_mode;
    logic [23:0] exposure_cycles;
    logic [15:0] readout_cycles;
  } fstc_cfg_s;

  typedef struct packed {
    logic        waiting;
    logic        exposing;
    logic        frame_start;
    logic        frame_end;
    logic        trigger_ready;
    logic        overtrigger;
  } fstc_status_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } fstc_sync_s;

endpackage

// >>> design/fstc_edge_sync.sv
`timescale 1ns/1ns
`include "fstc_map.svh"

module fstc_edge_sync (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  fstc_pkg::fstc_sync_s state;
  fstc_pkg::fstc_sync_s next_state;

  // -----------------------------------------------------------------
  // three stages; level changes only when stages two and three agree
  // -----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_state.sync = {state.sync[1:0], pin};
    if (state.sync[1] == state.sync[2]) begin
      next_state.level = state.sync[2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;
  assign rise  = next_state.level & ~state.level;
  assign fall  = ~next_state.level & state.level;

endmodule // fstc_edge_sync

// >>> tb/fstc_sva.sv
`timescale 1ns/1ns
// ---
// frame trigger checks
// ---
module fstc_sva (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire logic                  acq_stop,
  input wire logic                  trig_mode_on,
  input wire logic                  software_trigger,
  input wire logic                  trig_source,
  input wire fstc_pkg::fstc_status_s status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_sw_start: assert property (status.waiting && software_trigger && trig_mode_on
    && trig_source && !acq_stop |=> status.frame_start && status.exposing) else $error("sw start");
  a_sw_drop: assert property (trig_mode_on && trig_source && software_trigger
    && !status.waiting |=> status.overtrigger) else $error("sw not dropped");
  a_leave_wait: assert property (status.frame_start |-> !status.waiting)
    else $error("wait held");
  a_start_waited: assert property (status.frame_start |-> $past(status.waiting))
    else $error("start unqualified");
  a_no_restart: assert property (status.frame_start |-> !$past(status.exposing))
    else $error("restart");
  a_end_pulse: assert property (status.frame_end |-> $past(status.exposing) && !status.exposing)
    else $error("end");
  a_ready_wait: assert property (status.trigger_ready |-> status.waiting)
    else $error("ready");
  a_src_reset: assert property (!$past(nrst) |-> !trig_source)
    else $error("source reset");
  a_stop_idle: assert property (acq_stop |-> ##2 !status.waiting)
    else $error("stop");
endmodule // fstc_sva
bind fstc_trigger_ctrl fstc_sva u_sva (.clk(clk), .nrst(nrst), .acq_stop(acq_stop),
  .trig_mode_on(trig_mode_on), .software_trigger(software_trigger),
  .trig_source(trig_source), .status(status));

// >>> tb/fstc_host.sv
`timescale 1ns/1ns
module fstc_host (
  input  wire logic clk,
  output logic      sw,
  output logic      pin
);
  initial sw = 1'b0;
  initial pin = 1'b0;
  task sw_trig();
    @(posedge clk) sw <= 1'b1;
    @(posedge clk) sw <= 1'b0;
  endtask
  // idle level first, so a polarity change never fakes an active edge
  task pulse(input int w, input logic pol);
    @(posedge clk) pin <= pol;
    repeat (6) @(posedge clk);
    pin <= !pol;
    repeat (w) @(posedge clk);
    pin <= pol;
  endtask
endmodule // fstc_host

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        acq_start = 1'b0, acq_stop = 1'b0, mode_on = 1'b0, src_sel = 1'b0;
  logic        src_load = 1'b0, act = 1'b0, mode = 1'b0;
  logic [23:0] ecyc = 24'h000004;
  logic [15:0] rcyc = 16'h0003;
  logic        sw, pin, trig_source;
  logic [31:0] seed = 32'h0000bf7b;
  int          err_total = 0, tests_run = 0, nframes = 0, cur = 0, last_len = 0, novt = 0;
  fstc_pkg::fstc_status_s status;
  always #4 clk = ~clk;
  fstc_host h (.clk(clk), .sw(sw), .pin(pin));
  fstc_trigger_ctrl dut (.clk(clk), .nrst(nrst), .acq_start(acq_start), .acq_stop(acq_stop),
    .trig_mode_on(mode_on), .trig_source_sel(src_sel), .trig_source_load(src_load),
    .trig_activation(act), .exposure_mode(mode), .exposure_cycles(ecyc),
    .readout_cycles(rcyc), .software_trigger(sw), .external_frame_trigger_input(pin),
    .status(status), .trig_source(trig_source));
  always @(posedge clk) begin
    nframes <= nframes + int'(status.frame_start);
    novt <= novt + int'(status.overtrigger);
    if (status.exposing) cur <= cur + 1;
    else if (cur != 0) begin
      last_len <= cur;
      cur <= 0;
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_len(input logic [23:0] e);
    return (e == 24'h0) ? 1 : int'(e);
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task wait_ready();
    repeat (300) begin
      @(posedge clk);
      #1;
      if (status.waiting === 1'b1) break;
    end
    chk("waiting", 1, status.waiting);
  endtask
  // kind 0 software, 1 line timed with a second edge mid-exposure, 2 pulse width
  task frame(input int k, input logic [23:0] e, input int w);
    int n0, n1;
    n0 = nframes;
    n1 = novt;
    @(posedge clk) ecyc <= e;
    if (k == 0) begin
      h.sw_trig();
      h.sw_trig();
    end else begin
      h.pulse(w, act);
      if (k == 1) h.pulse(2, act);
    end
    wait_ready();
    chk("frames", n0 + 1, nframes);
    chk("length", (k == 2) ? w : exp_len(e), last_len);
    chk("overtrig", n1 + int'(k != 2), novt);
    if (k == 2) chk("ready", e <= w + 3, status.trigger_ready);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    int n, m;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk("source", 0, trig_source);
    chk("idle", 0, status.waiting);
    @(posedge clk) {mode_on, src_sel, src_load, acq_start} <= 4'hf;
    @(posedge clk) {src_load, acq_start} <= 2'h0;
    wait_ready();
    chk("source", 1, trig_source);
    frame(0, 24'h0, 0);
    repeat (3) frame(0, 24'(rnd() % 8 + 1), 0);
    @(posedge clk) {src_sel, src_load} <= 2'h1;
    @(posedge clk) src_load <= 1'b0;
    frame(1, 24'(rnd() % 8 + 20), 2);
    @(posedge clk) act <= 1'b1;
    frame(1, 24'(rnd() % 8 + 20), 3);
    @(posedge clk) {act, mode} <= 2'h1;
    frame(2, 24'h2, int'(rnd() % 8 + 3));
    frame(2, 24'h40, int'(rnd() % 8 + 3));
    n = nframes;
    m = novt;
    @(posedge clk) mode_on <= 1'b0;
    h.pulse(2, act);
    repeat (8) @(posedge clk);
    chk("disabled", n, nframes);
    chk("quiet", m, novt);
    @(posedge clk) {mode_on, acq_stop} <= 2'h3;
    @(posedge clk) acq_stop <= 1'b0;
    h.pulse(2, act);
    repeat (20) @(posedge clk);
    chk("stopped", n, nframes);
    wrap_up();
  end
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule // tb
